/* File: inc/rip_pkg.sv */
// package: offsets, reset values and field layout of the reference priority registers
package rip_pkg;
  localparam int          ADDR_W          = 7;
  localparam int          DATA_W          = 8;
  localparam int          RANK_W          = 4;
  localparam logic [6:0]  THIRD_PRIO_ADDR = 7'h1c;
  localparam logic [6:0]  DIFF_PRIO_ADDR  = 7'h1b;
  localparam logic [7:0]  DIFF_PRIO_RST   = 8'h00;
  localparam logic [7:0]  THIRD_PRIO_RST  = 8'h04;
  localparam logic [3:0]  RANK_OFF        = 4'h0;
  localparam int          TWO_LSB         = 4;
  localparam int          ONE_LSB         = 0;

  // rank values handed to the reference selector; zero means not eligible
  typedef struct packed {
    logic [3:0] diffInputTwoRank;
    logic [3:0] diffInputOneRank;
    logic [3:0] thirdInputRank;
  } rip_ranks_t;

  // register access strobes from the serial configuration port
  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [6:0] addr;
    logic [7:0] wrData;
  } rip_cfg_req_t;
endpackage : rip_pkg

/* File: verilog/rip_ref_priority_regs.sv */
// ref_input_priority_regs: differential and third input selection priority registers
`timescale 1ns/1ps
// Overview of operation
// RQ1: bits 7..4 of the differential register hold the second differential input rank.
// RQ2: a second differential rank of zero excludes it from selection, 1..15 rank it.
// RQ3: a non-zero second differential rank clears the second single-ended rank.
// RQ4: bits 3..0 of the differential register hold the first differential input rank.
// RQ5: a non-zero first differential rank clears the first single-ended rank.
// RQ6: the differential register is read/write and resets to zero.
// RQ7: the third input rank sits in bits 3..0 of its register, bits 7..4 unused.
// RQ8: the third input register lives at 1C, is read/write and resets to four.
// RQ9: a non-zero single-ended rank clears the matching differential rank; here a same-cycle differential write is kept instead.
module rip_ref_priority_regs (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire rip_pkg::rip_cfg_req_t cfgReq,
  output logic [7:0]                cfgRdData,
  input  wire logic                 seOneRankSet,
  input  wire logic                 seTwoRankSet,
  output logic                      clearSeOneRank,
  output logic                      clearSeTwoRank,
  output rip_pkg::rip_ranks_t       ranks,
  output logic [2:0]                eligible
);
  import rip_pkg::*;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic       diffWr;
  logic       thirdWr;
  logic [3:0] wrTwo;
  logic [3:0] wrOne;
  logic [7:0] diffPrio_reg;
  logic [7:0] diffPrio_next;
  logic [3:0] thirdRank_reg;

  // every check below runs on the register clock and sleeps through reset
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  always_comb begin
    diffWr  = 1'b0;
    thirdWr = 1'b0;
    if (cfgReq.wrEn && cfgReq.addr == DIFF_PRIO_ADDR) begin
      diffWr = 1'b1;
    end else if (cfgReq.wrEn && cfgReq.addr == THIRD_PRIO_ADDR) begin
      thirdWr = 1'b1;
    end
  end

  assign wrTwo = cfgReq.wrData[TWO_LSB +: RANK_W];
  assign wrOne = cfgReq.wrData[ONE_LSB +: RANK_W];

  // ----------------------------------------------------------------
  // differential priority register
  // ----------------------------------------------------------------
  // a register write wins over a same-cycle single-ended clear
  always_comb begin
    diffPrio_next = diffPrio_reg;
    if (diffWr) begin
      diffPrio_next = cfgReq.wrData;                          // RQ1 RQ4 RQ6
    end else begin
      if (seTwoRankSet) diffPrio_next[TWO_LSB +: RANK_W] = RANK_OFF;  // RQ9
      if (seOneRankSet) diffPrio_next[ONE_LSB +: RANK_W] = RANK_OFF;  // RQ9
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) diffPrio_reg <= DIFF_PRIO_RST;                   // RQ6
    else     diffPrio_reg <= diffPrio_next;
  end

  chk_two_rank_store: assert property (  // RQ1
    diffWr |=> ranks.diffInputTwoRank == $past(cfgReq.wrData[TWO_LSB +: RANK_W]))
    else $error("second differential rank not stored");

  chk_one_rank_store: assert property (  // RQ4
    diffWr |=> ranks.diffInputOneRank == $past(cfgReq.wrData[ONE_LSB +: RANK_W]))
    else $error("first differential rank not stored");

  chk_write_wins: assert property (  // RQ6
    diffWr |=> diffPrio_reg == $past(cfgReq.wrData))
    else $error("differential write not taken whole");

  chk_diff_hold: assert property (  // RQ6
    !diffWr && !seTwoRankSet && !seOneRankSet |=> $stable(diffPrio_reg))
    else $error("differential register changed without cause");

  chk_se_clears_diff: assert property (  // RQ9
    seTwoRankSet && !diffWr |=> ranks.diffInputTwoRank == RANK_OFF)
    else $error("single-ended set did not clear differential rank");

  chk_se_one_clears: assert property (  // RQ9
    seOneRankSet && !diffWr |=> ranks.diffInputOneRank == RANK_OFF)
    else $error("first single-ended set did not clear differential rank");

  // ----------------------------------------------------------------
  // single-ended clear pulses
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clearSeTwoRank <= 1'b0;
      clearSeOneRank <= 1'b0;
    end else begin
      clearSeTwoRank <= diffWr && (wrTwo != RANK_OFF);        // RQ3
      clearSeOneRank <= diffWr && (wrOne != RANK_OFF);        // RQ5
    end
  end

  chk_se_two_clear: assert property (  // RQ3
    diffWr && wrTwo != RANK_OFF |=> clearSeTwoRank ##1 (!clearSeTwoRank || $past(diffWr)))
    else $error("second single-ended clear missing");

  chk_se_two_cause: assert property (  // RQ3
    clearSeTwoRank |-> $past(diffWr) && $past(wrTwo) != RANK_OFF)
    else $error("second single-ended clear without cause");

  chk_se_one_clear: assert property (  // RQ5
    clearSeOneRank |-> $past(diffWr) && $past(wrOne) != RANK_OFF)
    else $error("first single-ended clear without cause");

  chk_se_one_fires: assert property (  // RQ5
    diffWr && wrOne != RANK_OFF |=> clearSeOneRank)
    else $error("first single-ended clear missing");

  chk_clear_idle: assert property (  // RQ3
    !diffWr |=> !clearSeTwoRank && !clearSeOneRank)
    else $error("single-ended clear without a write");

  chk_diff_reset: assert property (@(posedge sys_clk)  // RQ6
    $past(rst) |-> diffPrio_reg == DIFF_PRIO_RST && !clearSeOneRank && !clearSeTwoRank)
    else $error("differential register reset value wrong");

  // ----------------------------------------------------------------
  // third input priority register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst)          thirdRank_reg <= THIRD_PRIO_RST[ONE_LSB +: RANK_W];  // RQ8
    else if (thirdWr) thirdRank_reg <= cfgReq.wrData[ONE_LSB +: RANK_W];   // RQ7
  end

  chk_third_store: assert property (  // RQ7
    thirdWr |=> thirdRank_reg == $past(cfgReq.wrData[ONE_LSB +: RANK_W]))
    else $error("third input rank not stored");

  chk_third_hold: assert property (  // RQ8
    !thirdWr |=> $stable(thirdRank_reg))
    else $error("third input rank changed without a write");

  chk_third_reset: assert property (@(posedge sys_clk)  // RQ8
    $past(rst) |-> thirdRank_reg == THIRD_PRIO_RST[ONE_LSB +: RANK_W] && eligible[0])
    else $error("third register reset value wrong");

  // ----------------------------------------------------------------
  // read-back and rank outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfgRdData <= 8'h00;
    end else if (cfgReq.rdEn) begin
      if (cfgReq.addr == DIFF_PRIO_ADDR) begin
        cfgRdData <= diffPrio_reg;
      end else if (cfgReq.addr == THIRD_PRIO_ADDR) begin
        cfgRdData <= {4'h0, thirdRank_reg};                   // RQ7
      end else begin
        cfgRdData <= 8'h00;
      end
    end
  end

  assign ranks.diffInputTwoRank = diffPrio_reg[TWO_LSB +: RANK_W];
  assign ranks.diffInputOneRank = diffPrio_reg[ONE_LSB +: RANK_W];
  assign ranks.thirdInputRank   = thirdRank_reg;
  assign eligible[2] = (ranks.diffInputTwoRank != RANK_OFF);  // RQ2
  assign eligible[1] = (ranks.diffInputOneRank != RANK_OFF);  // RQ4
  assign eligible[0] = (thirdRank_reg != RANK_OFF);           // RQ7

  // ----------------------------------------------------------------
  // read-back and rank checks
  // ----------------------------------------------------------------
  chk_diff_read: assert property (  // RQ6
    cfgReq.rdEn && cfgReq.addr == DIFF_PRIO_ADDR |=> cfgRdData == $past(diffPrio_reg))
    else $error("differential register read-back wrong");

  chk_third_read: assert property (  // RQ7
    cfgReq.rdEn && cfgReq.addr == THIRD_PRIO_ADDR |=> cfgRdData == {4'h0, $past(thirdRank_reg)})
    else $error("third register read-back wrong");

  chk_other_read: assert property (  // RQ6
    cfgReq.rdEn && cfgReq.addr != DIFF_PRIO_ADDR && cfgReq.addr != THIRD_PRIO_ADDR
      |=> cfgRdData == 8'h00)
    else $error("unmapped address read not zero");

  chk_rd_hold: assert property (  // RQ6
    !cfgReq.rdEn |=> $stable(cfgRdData))
    else $error("read data changed without a read");

  chk_two_zero_excl: assert property (  // RQ2
    diffWr && wrTwo == RANK_OFF |=> !eligible[2])
    else $error("second differential eligibility wrong");

  chk_two_elig: assert property (  // RQ2
    diffWr && wrTwo != RANK_OFF |=> eligible[2])
    else $error("second differential input not eligible");

  chk_one_elig: assert property (  // RQ4
    diffWr |=> eligible[1] == ($past(wrOne) != RANK_OFF))
    else $error("first differential eligibility wrong");

  chk_third_elig: assert property (  // RQ7
    thirdWr |=> eligible[0] == ($past(cfgReq.wrData[ONE_LSB +: RANK_W]) != RANK_OFF))
    else $error("third input eligibility wrong");

  // ----------------------------------------------------------------
  // scenario covers
  // ----------------------------------------------------------------
  cov_two_nonzero: cover property (diffWr && wrTwo != RANK_OFF ##1 clearSeTwoRank);
  cov_se_clear:    cover property (seOneRankSet && eligible[1] ##1 !eligible[1]);
  cov_se_two:      cover property (seTwoRankSet && eligible[2] ##1 !eligible[2]);
  cov_third_write: cover property (thirdWr ##1 cfgReq.rdEn && cfgReq.addr == THIRD_PRIO_ADDR);
  cov_diff_read:   cover property (diffWr ##1 cfgReq.rdEn && cfgReq.addr == DIFF_PRIO_ADDR);
endmodule : rip_ref_priority_regs

/* File: verification/test_ref_input_priority_regs.sv */
// testbench for the reference input priority registers
`timescale 1ns/1ps
module test_ref_input_priority_regs;
  import rip_pkg::*;
  logic         sysClk       = 1'b0;
  logic         rst          = 1'b1;
  rip_cfg_req_t cfgReq       = '0;
  logic         seOneRankSet = 1'b0;
  logic         seTwoRankSet = 1'b0;
  logic [7:0]   cfgRdData;
  logic         clearSeOneRank;
  logic         clearSeTwoRank;
  rip_ranks_t   ranks;
  logic [2:0]   eligible;
  int           failCount    = 0;
  int           nChecks      = 0;

  always #20 sysClk = ~sysClk;

  rip_ref_priority_regs dut (.sys_clk(sysClk), .rst(rst), .cfgReq(cfgReq),
    .cfgRdData(cfgRdData), .seOneRankSet(seOneRankSet), .seTwoRankSet(seTwoRankSet),
    .clearSeOneRank(clearSeOneRank), .clearSeTwoRank(clearSeTwoRank),
    .ranks(ranks), .eligible(eligible));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task mismatch(input string what);
    failCount++;
    $display("wrong value at %0t: %s", $time, what);
  endtask : mismatch

  task give_verdict;
    $display("checks %0d mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict

  task wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge sysClk) cfgReq <= '{1'b1, 1'b0, a, d};
    @(posedge sysClk) cfgReq <= '0;
    #1;
  endtask : wr

  task rd(input logic [6:0] a);
    @(posedge sysClk) cfgReq <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge sysClk) cfgReq <= '0;
    #1;
  endtask : rd

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset;
    #1;
    nChecks++;
    if (ranks !== 12'h004) mismatch("ranks after reset");
    nChecks++;
    if (eligible !== 3'h1) mismatch("eligible after reset");
    nChecks++;
    if ({clearSeTwoRank, clearSeOneRank} !== 2'h0) mismatch("clear after reset");
    rd(DIFF_PRIO_ADDR);
    nChecks++;
    if (cfgRdData !== 8'h00) mismatch("diff read after reset");
    rd(THIRD_PRIO_ADDR);
    nChecks++;
    if (cfgRdData !== 8'h04) mismatch("third read after reset");
  endtask : t_reset

  task t_diff;
    wr(DIFF_PRIO_ADDR, 8'h31);
    nChecks++;
    if (ranks !== 12'h314) mismatch("ranks after write 31");
    nChecks++;
    if ({clearSeTwoRank, clearSeOneRank} !== 2'h3) mismatch("clears missing");
    @(posedge sysClk) #1;
    nChecks++;
    if ({clearSeTwoRank, clearSeOneRank} !== 2'h0) mismatch("clears stuck");
    wr(DIFF_PRIO_ADDR, 8'h50);
    nChecks++;
    if ({clearSeTwoRank, clearSeOneRank} !== 2'h2) mismatch("clears after 50");
    nChecks++;
    if (eligible !== 3'h5) mismatch("eligible after 50");
    rd(DIFF_PRIO_ADDR);
    nChecks++;
    if (cfgRdData !== 8'h50) mismatch("diff read-back");
  endtask : t_diff

  task t_third;
    wr(THIRD_PRIO_ADDR, 8'hf9);
    rd(THIRD_PRIO_ADDR);
    nChecks++;
    if (cfgRdData !== 8'h09) mismatch("third read-back");
    nChecks++;
    if (ranks.thirdInputRank !== 4'h9) mismatch("third rank");
    wr(THIRD_PRIO_ADDR, 8'h00);
    nChecks++;
    if (eligible !== 3'h4) mismatch("third still eligible");
    rd(7'h1d);
    nChecks++;
    if (cfgRdData !== 8'h00) mismatch("unmapped read");
  endtask : t_third

  task t_se_clear;
    wr(DIFF_PRIO_ADDR, 8'h66);
    @(posedge sysClk) seTwoRankSet <= 1'b1;
    @(posedge sysClk) seTwoRankSet <= 1'b0;
    #1;
    nChecks++;
    if (ranks.diffInputTwoRank !== 4'h0) mismatch("second rank kept");
    nChecks++;
    if (eligible !== 3'h2) mismatch("eligible after clear");
    @(posedge sysClk) seOneRankSet <= 1'b1;
    @(posedge sysClk) seOneRankSet <= 1'b0;
    rd(DIFF_PRIO_ADDR);
    nChecks++;
    if (cfgRdData !== 8'h00) mismatch("first rank kept");
  endtask : t_se_clear

  task t_write_wins;
    @(posedge sysClk) begin
      cfgReq       <= '{1'b1, 1'b0, DIFF_PRIO_ADDR, 8'h23};
      seTwoRankSet <= 1'b1;
      seOneRankSet <= 1'b1;
    end
    @(posedge sysClk) begin
      cfgReq       <= '0;
      seTwoRankSet <= 1'b0;
      seOneRankSet <= 1'b0;
    end
    #1;
    nChecks++;
    if (ranks[11:4] !== 8'h23) mismatch("write lost");
    nChecks++;
    if ({clearSeTwoRank, clearSeOneRank} !== 2'h3) mismatch("contested clears");
  endtask : t_write_wins

  task t_reset_again;
    wr(DIFF_PRIO_ADDR, 8'h77);
    wr(THIRD_PRIO_ADDR, 8'h0a);
    rd(THIRD_PRIO_ADDR);
    nChecks++;
    if (cfgRdData !== 8'h0a) mismatch("third read before reset");
    @(posedge sysClk) rst <= 1'b1;
    repeat (2) @(posedge sysClk);
    rst <= 1'b0;
    #1;
    nChecks++;
    if (ranks !== 12'h004) mismatch("ranks after reset 2");
    nChecks++;
    if (cfgRdData !== 8'h00) mismatch("read data after reset 2");
    nChecks++;
    if ({clearSeTwoRank, clearSeOneRank} !== 2'h0) mismatch("clear after reset 2");
    rd(DIFF_PRIO_ADDR);
    nChecks++;
    if (cfgRdData !== 8'h00) mismatch("diff read after reset 2");
  endtask : t_reset_again

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge sysClk);
    rst <= 1'b0;
    t_reset();
    t_diff();
    t_third();
    t_se_clear();
    t_write_wins();
    t_reset_again();
    give_verdict();
  end

  initial begin
    #20000;
    failCount++;
    give_verdict();
  end
endmodule : test_ref_input_priority_regs
